// ### hw/peom_monitor.sv
// position error overflow monitor: error counter, servo-on sequence, speed cap and alarms
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`include "peom_defs.svh"

// Functional notes
// RL1: error counter holds commanded minus actual position
// RL2: monitor acts only in position control
// RL3: error above alarm level raises alarm, stops; the code raises it only while servo on is set
// RL4: host sets level above expected error times margin
// RL5: servo-on with large held error raises alarm
// RL6: servo-on drives residual error toward zero
// RL7: clearing speed capped by servo-on speed limit
// RL8: new references during capped clearing raise alarm; the code raises it only when the error is also above the position alarm level
// RL9: alarms stay set until explicit clear
module peom_monitor
   import peom_pkg::*;
#(
   parameter int ERR_WIDTH = 40
) (
   input wire logic clk_sys,             // system clock, 200 MHz
   input wire logic rst,                 // async reset, active high
   input wire logic [7:0] address,       // avalon byte address
   input wire logic read,                // avalon read
   input wire logic write,               // avalon write
   input wire logic [31:0] writedata,    // avalon write data
   input wire logic [3:0] byteenable,    // avalon byte enables
   output logic [31:0] readdata,         // avalon read data
   output logic waitrequest,             // avalon stall
   input wire peom_pos_s pos_in,         // host reference and encoder deltas
   output logic motor_stop_q,            // stop the motor
   output logic speed_limit_active_q,    // speed cap in force
   output logic [15:0] speed_cap_q,      // cap in mm/s
   output logic signed [31:0] clear_cmd_q, // speed command toward zero error
   output peom_alarm_s alarm_q           // overflow alarms
);
   initial begin
      if (ERR_WIDTH < 33 || ERR_WIDTH > 64) $error("peom_monitor: ERR_WIDTH out of range");
   end

   logic signed [ERR_WIDTH-1:0] err;
   logic [ERR_WIDTH-1:0] err_abs;
   logic [31:0] pos_lvl;
   logic [31:0] son_lvl;
   logic [15:0] spd_lim;
   logic [1:0] ctrl;
   logic alarm_clear;
   logic [31:0] status;
   logic [31:0] rd_int;
   logic wait_int;
   peom_state_e state_q;
   peom_state_e state_d;
   logic servo_on_q;
   logic servo_rise;
   logic pos_mode;
   logic over_pos;
   logic over_son;
   logic set_pos;
   logic set_son;
   logic set_spd;
   logic signed [ERR_WIDTH-1:0] cap_ext;
   logic [31:0] rd_q;
   logic wait_q;
   logic ref_seen_q;

   // two-deep register of the live inputs since they may come from pins
   peom_pos_s pos_s1_q;
   peom_pos_s pos_q;

   // two flops before the counter reads the deltas
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pos_s1_q <= '0;
         pos_q <= '0;
      end else begin
         pos_s1_q <= pos_in;
         pos_q <= pos_s1_q;
      end
   end

   peom_err_counter #(
      .WIDTH(ERR_WIDTH)
   ) u_cnt (
      .clk_sys(clk_sys),
      .rst(rst),
      .pos(pos_q),
      .err_q(err),
      .err_abs(err_abs)
   );

   peom_avmm_regs u_regs (
      .clk_sys(clk_sys),
      .rst(rst),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .byteenable(byteenable),
      .readdata(rd_int),
      .waitrequest(wait_int),
      .status(status),
      .err_word(err[31:0]),
      .pos_lvl_q(pos_lvl),
      .son_lvl_q(son_lvl),
      .spd_lim_q(spd_lim),
      .ctrl_q(ctrl),
      .clear_q(alarm_clear)
   );

   // bus answer straight from flops: waitrequest drops in the cycle the slave accepts,
   // readdata was registered one edge earlier from the same held address
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_q <= 32'h0000_0000;
         wait_q <= 1'b1;
      end else begin
         rd_q <= rd_int;
         wait_q <= !wait_int;
      end
   end
   assign readdata = rd_q;
   assign waitrequest = wait_q;

   assign pos_mode = ctrl[`PEOM_CTRL_POS_MODE];
   assign servo_rise = ctrl[`PEOM_CTRL_SERVO_ON] && !servo_on_q;

   // strict comparison against the levels, which take effect at once
   assign over_pos = err_abs > ERR_WIDTH'(pos_lvl); // RL3
   assign over_son = err_abs > ERR_WIDTH'(son_lvl); // RL5

   // overflow checks gated by position control
   assign set_pos = pos_mode && ctrl[`PEOM_CTRL_SERVO_ON] && over_pos; // RL2 RL3
   assign set_son = pos_mode && servo_rise && over_son; // RL2 RL5
   // the counter shows a reference one cycle after it arrives, so remember the arrival
   assign set_spd = pos_mode && state_q == PEOM_CLEARING && (pos_q.ref_valid || ref_seen_q) && over_pos; // RL2 RL8

   // reference arrival, one cycle old
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ref_seen_q <= 1'b0;
      end else begin
         ref_seen_q <= pos_q.ref_valid;
      end
   end

   // servo-on edge tracker
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         servo_on_q <= 1'b0;
      end else begin
         servo_on_q <= ctrl[`PEOM_CTRL_SERVO_ON];
      end
   end

   // power sequence: leave clearing once the residual error is gone
   always_comb begin
      state_d = state_q;
      case (state_q)
         PEOM_OFF: begin
            if (servo_rise) begin
               state_d = (pos_mode && err != '0) ? PEOM_CLEARING : PEOM_RUN; // RL6
            end
         end
         PEOM_CLEARING: begin
            if (!ctrl[`PEOM_CTRL_SERVO_ON]) begin
               state_d = PEOM_OFF;
            end else if (err == '0 || !pos_mode) begin
               state_d = PEOM_RUN;
            end
         end
         PEOM_RUN: begin
            if (!ctrl[`PEOM_CTRL_SERVO_ON]) begin
               state_d = PEOM_OFF;
            end
         end
         default: state_d = PEOM_OFF;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= PEOM_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // sticky alarms; a set in the clearing cycle wins
   always_ff @(posedge clk_sys or posedge rst) begin // RL9
      if (rst) begin
         alarm_q <= '0;
      end else begin
         alarm_q.pos_ovf <= set_pos || (alarm_q.pos_ovf && !alarm_clear); // RL3
         alarm_q.son_ovf <= set_son || (alarm_q.son_ovf && !alarm_clear); // RL5
         alarm_q.spd_ovf <= set_spd || (alarm_q.spd_ovf && !alarm_clear); // RL8
      end
   end

   // stop holds while any alarm stands, and a stop rises in the same cycle as the alarm
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         motor_stop_q <= 1'b0;
      end else begin
         motor_stop_q <= set_pos || set_son || set_spd || ((|alarm_q) && !alarm_clear); // RL3
      end
   end

   assign cap_ext = ERR_WIDTH'(spd_lim);

   // clearing command: the error itself, saturated at the cap while clearing
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         clear_cmd_q <= 32'h0000_0000;
         speed_limit_active_q <= 1'b0;
         speed_cap_q <= 16'h0000;
      end else begin
         speed_limit_active_q <= state_d == PEOM_CLEARING; // RL7
         speed_cap_q <= spd_lim; // RL7
         if (state_d != PEOM_CLEARING || set_pos || set_son || set_spd) begin
            clear_cmd_q <= 32'h0000_0000;
         end else if (err > cap_ext) begin
            clear_cmd_q <= 32'(cap_ext); // RL6 RL7
         end else if (err < -cap_ext) begin
            clear_cmd_q <= 32'(-cap_ext); // RL6 RL7
         end else begin
            clear_cmd_q <= 32'(err); // RL6
         end
      end
   end

   // status word for software
   always_comb begin
      status = 32'h0000_0000;
      status[`PEOM_ST_POS_OVF] = alarm_q.pos_ovf;
      status[`PEOM_ST_SON_OVF] = alarm_q.son_ovf;
      status[`PEOM_ST_SPD_OVF] = alarm_q.spd_ovf;
      status[`PEOM_ST_STOP] = motor_stop_q;
      status[`PEOM_ST_LIMITING] = speed_limit_active_q;
      status[`PEOM_ST_SERVO_ON] = state_q != PEOM_OFF;
   end
endmodule

// ### shared/peom_defs.svh
// register offsets, field positions and reset values for the error overflow monitor
`ifndef PEOM_DEFS_SVH
`define PEOM_DEFS_SVH

// register byte addresses (word index times four)
`define PEOM_ADDR_CTRL      8'h00
`define PEOM_ADDR_POS_LVL   8'h04
`define PEOM_ADDR_SON_LVL   8'h08
`define PEOM_ADDR_SPD_LIM   8'h0C
`define PEOM_ADDR_STATUS    8'h10
`define PEOM_ADDR_ERROR     8'h14
`define PEOM_ADDR_CLEAR     8'h18

// control fields
`define PEOM_CTRL_POS_MODE  0
`define PEOM_CTRL_SERVO_ON  1

// status fields
`define PEOM_ST_POS_OVF     0
`define PEOM_ST_SON_OVF     1
`define PEOM_ST_SPD_OVF     2
`define PEOM_ST_STOP        3
`define PEOM_ST_LIMITING    4
`define PEOM_ST_SERVO_ON    5

// reset values and ranges of the levels
`define PEOM_LVL_DEFAULT    32'h0050_0000
`define PEOM_LVL_MIN        32'h0000_0001
`define PEOM_LVL_MAX        32'h3FFF_FFFF
`define PEOM_SPD_DEFAULT    16'h2710
`define PEOM_SPD_MAX        16'h2710

// read answer for an unmapped address
`define PEOM_UNMAPPED       32'h0000_0000

`endif

// ### shared/peom_pkg.sv
// types shared by the error overflow monitor
package peom_pkg;

   // one position sample from the host and the encoder
   typedef struct packed {
      logic        ref_valid;
      logic [31:0] ref_delta;
      logic        fb_valid;
      logic [31:0] fb_delta;
   } peom_pos_s;

   // alarm flags
   typedef struct packed {
      logic spd_ovf;
      logic son_ovf;
      logic pos_ovf;
   } peom_alarm_s;

   // servo power sequence
   typedef enum logic [1:0] {
      PEOM_OFF,
      PEOM_CLEARING,
      PEOM_RUN
   } peom_state_e;

endpackage

// ### hw/peom_err_counter.sv
// signed position error accumulator with magnitude output
`include "peom_defs.svh"
module peom_err_counter
   import peom_pkg::*;
#(
   parameter int WIDTH = 40
) (
   input wire logic clk_sys,              // system clock
   input wire logic rst,                  // async reset
   input wire peom_pos_s pos,             // reference and feedback deltas
   output logic signed [WIDTH-1:0] err_q, // error counter
   output logic [WIDTH-1:0] err_abs       // magnitude
);
   initial begin
      if (WIDTH < 33 || WIDTH > 64) $error("peom_err_counter: WIDTH out of range");
   end

   logic signed [WIDTH-1:0] ref_ext;
   logic signed [WIDTH-1:0] fb_ext;

   // deltas sign-extended; an idle side contributes zero
   assign ref_ext = pos.ref_valid ? WIDTH'(signed'(pos.ref_delta)) : '0;
   assign fb_ext = pos.fb_valid ? WIDTH'(signed'(pos.fb_delta)) : '0;

   // commanded minus actual, kept wide so it cannot wrap in practice
   always_ff @(posedge clk_sys or posedge rst) begin // RL1
      if (rst) begin
         err_q <= '0;
      end else begin
         err_q <= err_q + ref_ext - fb_ext;
      end
   end

   assign err_abs = err_q[WIDTH-1] ? WIDTH'(-err_q) : WIDTH'(err_q);
endmodule

// ### hw/peom_avmm_regs.sv
// avalon-mm slave holding the level, limit and control registers
`include "peom_defs.svh"
module peom_avmm_regs
   import peom_pkg::*;
(
   input wire logic clk_sys,             // system clock
   input wire logic rst,                 // async reset
   input wire logic [7:0] address,       // byte address
   input wire logic read,                // read strobe
   input wire logic write,               // write strobe
   input wire logic [31:0] writedata,    // write data
   input wire logic [3:0] byteenable,    // byte lanes
   output logic [31:0] readdata,         // read data
   output logic waitrequest,             // stall
   input wire logic [31:0] status,       // live status
   input wire logic [31:0] err_word,     // live error, low 32 bits
   output logic [31:0] pos_lvl_q,        // position error alarm level
   output logic [31:0] son_lvl_q,        // servo-on error alarm level
   output logic [15:0] spd_lim_q,        // servo-on speed limit
   output logic [1:0] ctrl_q,            // mode and servo on
   output logic clear_q                  // alarm clear pulse
);
   logic ack_q;
   logic [31:0] wmask;
   logic [31:0] wval_pos;
   logic [31:0] wval_son;
   logic [31:0] wval_spd;

   // every access answers on its second cycle: one wait state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (read || write) && !ack_q;
      end
   end
   assign waitrequest = (read || write) && !ack_q;

   assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
   assign wval_pos = (pos_lvl_q & ~wmask) | (writedata & wmask);
   assign wval_son = (son_lvl_q & ~wmask) | (writedata & wmask);
   assign wval_spd = ({16'h0000, spd_lim_q} & ~wmask) | (writedata & wmask);

   // writes land at the accepting edge; out-of-range levels are clamped, taking effect at once
   always_ff @(posedge clk_sys or posedge rst) begin // RL3 RL5 RL7
      if (rst) begin
         pos_lvl_q <= `PEOM_LVL_DEFAULT;
         son_lvl_q <= `PEOM_LVL_DEFAULT;
         spd_lim_q <= `PEOM_SPD_DEFAULT;
         ctrl_q <= 2'h0;
         clear_q <= 1'b0;
      end else begin
         clear_q <= 1'b0;
         if (write && ack_q) begin
            case (address)
               `PEOM_ADDR_CTRL: begin
                  if (byteenable[0]) ctrl_q <= writedata[1:0];
               end
               `PEOM_ADDR_POS_LVL: begin
                  pos_lvl_q <= (wval_pos == 32'h0000_0000) ? `PEOM_LVL_MIN :
                     (wval_pos > `PEOM_LVL_MAX) ? `PEOM_LVL_MAX : wval_pos;
               end
               `PEOM_ADDR_SON_LVL: begin
                  son_lvl_q <= (wval_son == 32'h0000_0000) ? `PEOM_LVL_MIN :
                     (wval_son > `PEOM_LVL_MAX) ? `PEOM_LVL_MAX : wval_son;
               end
               `PEOM_ADDR_SPD_LIM: begin
                  spd_lim_q <= (wval_spd > 32'(`PEOM_SPD_MAX)) ? `PEOM_SPD_MAX : wval_spd[15:0];
               end
               `PEOM_ADDR_CLEAR: begin
                  clear_q <= byteenable[0] && writedata[0];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // read mux, unmapped reads as zero
   always_comb begin
      case (address)
         `PEOM_ADDR_CTRL: readdata = {30'h0000_0000, ctrl_q};
         `PEOM_ADDR_POS_LVL: readdata = pos_lvl_q;
         `PEOM_ADDR_SON_LVL: readdata = son_lvl_q;
         `PEOM_ADDR_SPD_LIM: readdata = {16'h0000, spd_lim_q};
         `PEOM_ADDR_STATUS: readdata = status;
         `PEOM_ADDR_ERROR: readdata = err_word;
         default: readdata = `PEOM_UNMAPPED;
      endcase
   end
endmodule

// ### sim/peom_monitor_sva.sv
// assertion checker for the error overflow monitor ports
`include "peom_defs.svh"
module peom_monitor_sva
   import peom_pkg::*;
#(
   parameter int ERR_WIDTH = 40
) (
   input wire logic clk_sys, // clock
   input wire logic rst, // reset
   input wire logic [7:0] address, // bus address
   input wire logic read, // bus read
   input wire logic write, // bus write
   input wire logic [31:0] writedata, // write data
   input wire logic [3:0] byteenable, // lanes
   input wire logic [31:0] readdata, // read data
   input wire logic waitrequest, // stall
   input wire peom_pos_s pos_in, // position deltas
   input wire logic motor_stop_q, // stop
   input wire logic speed_limit_active_q, // cap in force
   input wire logic [15:0] speed_cap_q, // cap
   input wire logic signed [31:0] clear_cmd_q, // clearing command
   input wire peom_alarm_s alarm_q // alarms
);
   logic [3:0] clr_age_q; // cycles since an accepted clear
   logic mode_q; // position mode as last written
   logic acc; // write accepted this edge
   assign acc = write && !waitrequest;
   // age of the last clear, saturating so old clears stop counting
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         clr_age_q <= 4'hF;
      end else if (acc && address == `PEOM_ADDR_CLEAR && writedata[0]) begin
         clr_age_q <= 4'h0;
      end else if (clr_age_q != 4'hF) begin
         clr_age_q <= clr_age_q + 4'h1;
      end
   end
   // shadow of the mode bit, lane 0 only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_q <= 1'b0;
      end else if (acc && address == `PEOM_ADDR_CTRL && byteenable[0]) begin
         mode_q <= writedata[`PEOM_CTRL_POS_MODE];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_bus_ans; (read || write) |-> ##[0:4] !waitrequest; endproperty
   property p_unmapped; (read && !waitrequest && address > `PEOM_ADDR_CLEAR) |-> readdata == `PEOM_UNMAPPED; endproperty
   property p_stop; alarm_q != 3'h0 |-> motor_stop_q; endproperty
   property p_stop_rel; (alarm_q == 3'h0) ##1 (alarm_q == 3'h0) |-> !$past(motor_stop_q); endproperty
   property p_sticky; (|($past(alarm_q) & ~alarm_q)) |-> clr_age_q < 4'h4; endproperty
   property p_mode; $rose(alarm_q.pos_ovf) |-> mode_q || $past(mode_q); endproperty
   property p_idle_cmd; !speed_limit_active_q |-> clear_cmd_q == 32'sh0; endproperty
   property p_cap;
      speed_limit_active_q |-> clear_cmd_q <= $signed({16'h0000, speed_cap_q})
         && clear_cmd_q >= -$signed({16'h0000, speed_cap_q});
   endproperty
   property p_spd; $rose(alarm_q.spd_ovf) |-> alarm_q.pos_ovf && $past(speed_limit_active_q); endproperty
   a_bus_ans: assert property (p_bus_ans) else $error("bus request not answered in time");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_stop: assert property (p_stop) else $error("alarm without motor stop");
   a_stop_rel: assert property (p_stop_rel) else $error("motor stop without alarm");
   a_sticky: assert property (p_sticky) else $error("alarm dropped without clear");
   a_mode: assert property (p_mode) else $error("alarm outside position mode");
   a_idle_cmd: assert property (p_idle_cmd) else $error("clearing command while not clearing");
   a_cap: assert property (p_cap) else $error("clearing command above cap");
   a_spd: assert property (p_spd) else $error("capped alarm outside clearing");
   c_pos: cover property ($rose(alarm_q.pos_ovf));
   c_spd: cover property ($rose(alarm_q.spd_ovf));
   c_lim: cover property ($rose(speed_limit_active_q));
endmodule

bind peom_monitor peom_monitor_sva #(.ERR_WIDTH(ERR_WIDTH)) u_sva (.clk_sys(clk_sys), .rst(rst),
   .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
   .readdata(readdata), .waitrequest(waitrequest), .pos_in(pos_in), .motor_stop_q(motor_stop_q),
   .speed_limit_active_q(speed_limit_active_q), .speed_cap_q(speed_cap_q), .clear_cmd_q(clear_cmd_q),
   .alarm_q(alarm_q));

// ### sim/peom_host_model.sv
// host controller model sending reference and feedback steps
module peom_host_model
   import peom_pkg::*;
(
   input wire logic clk_sys, // clock
   input wire logic rst, // reset
   input wire logic ref_go, // one reference step
   input wire logic [31:0] ref_amt, // reference step size
   input wire logic fb_go, // one feedback step
   input wire logic [31:0] fb_amt, // feedback step size
   output peom_pos_s pos // deltas toward the monitor
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle deltas toggle so a stale value is never mistaken for a step
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pos <= '0;
      end else begin
         pos.ref_valid <= ref_go;
         pos.ref_delta <= ref_go ? ref_amt : ~pos.ref_delta;
         pos.fb_valid <= fb_go;
         pos.fb_delta <= fb_go ? fb_amt : ~pos.fb_delta;
      end
   end
endmodule

// ### sim/tb_top.sv
// self-checking bench for the error overflow monitor
module tb_top
   import peom_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, rst, read, write, waitrequest, ref_go, fb_go, motor_stop_q, speed_limit_active_q;
   logic [7:0] address;
   logic [3:0] byteenable;
   logic [15:0] speed_cap_q;
   logic signed [31:0] clear_cmd_q;
   logic [31:0] writedata, readdata, ref_amt, fb_amt, q, rnd, lv, sv, cp, s_al, s_stop, s_lim, s_cc, s_cap;
   peom_alarm_s alarm_q;
   peom_pos_s pos;
   int n_mismatch, samples_checked;
   logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
   logic [31:0] re [7] = '{32'h0, 32'h0050_0000, 32'h0050_0000, 32'h0000_2710, 32'h0, 32'h0, 32'h0};
   peom_monitor dut (.clk_sys(clk_sys), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .pos_in(pos), .motor_stop_q(motor_stop_q), .speed_limit_active_q(speed_limit_active_q),
      .speed_cap_q(speed_cap_q), .clear_cmd_q(clear_cmd_q), .alarm_q(alarm_q));
   peom_host_model host (.clk_sys(clk_sys), .rst(rst), .ref_go(ref_go), .ref_amt(ref_amt),
      .fb_go(fb_go), .fb_amt(fb_amt), .pos(pos));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one bus transfer; request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int i;
      logic s;
      s = 1'b1;
      i = 0;
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      while (s !== 1'b0 && i < 20) begin
         @(posedge clk_sys);
         s = waitrequest;
         r = readdata;
         i++;
      end
      if (s !== 1'b0) begin
         n_mismatch++;
         stop_test();
      end else begin
         write <= 1'b0;
         read <= 1'b0;
      end
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask
   // outputs are captured mid-cycle, away from the updating edge
   task automatic snap();
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      s_al = {29'h0, alarm_q};
      s_stop = {31'h0, motor_stop_q};
      s_lim = {31'h0, speed_limit_active_q};
      s_cc = clear_cmd_q;
      s_cap = {16'h0, speed_cap_q};
      @(posedge clk_sys);
   endtask
   task automatic push(input logic r, input logic [31:0] amt);
      ref_go <= r;
      fb_go <= !r;
      ref_amt <= amt;
      fb_amt <= amt;
      @(posedge clk_sys);
      ref_go <= 1'b0;
      fb_go <= 1'b0;
      repeat (4) @(posedge clk_sys);
      snap();
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      stop_test();
   end
   initial begin
      rst = 1'b1;
      {read, write, ref_go, fb_go} = 4'h0;
      {address, writedata, ref_amt, fb_amt} = '0;
      byteenable = 4'hF;
      rnd = 32'h0207_517e;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      foreach (ra[i]) rd(ra[i], re[i]);
      wr(8'h04, 32'h0);
      rd(8'h04, 32'h0000_0001);
      wr(8'h04, 32'hFFFF_FFFF);
      rd(8'h04, 32'h3FFF_FFFF);
      wr(8'h0C, 32'h0000_FFFF);
      rd(8'h0C, 32'h0000_2710);
      wr(8'h1C, rnd);
      rd(8'h1C, 32'h0);
      rnd = lfsr(rnd);
      lv = (rnd & 32'h0000_0FFF) + 32'h0000_0100;
      wr(8'h04, lv);
      wr(8'h00, 32'h2);
      push(1'b1, lv + 5);
      chk(s_al, 32'h0);
      rd(8'h14, lv + 5);
      push(1'b0, lv + 5);
      rd(8'h14, 32'h0);
      wr(8'h00, 32'h3);
      push(1'b1, lv);
      chk(s_al, 32'h0);
      push(1'b1, 32'h1);
      chk(s_al, 32'h1);
      chk(s_stop, 32'h1);
      rd(8'h10, 32'h29);
      push(1'b0, lv + 1);
      chk(s_al, 32'h1);
      rd(8'h14, 32'h0);
      wr(8'h18, 32'h1);
      snap();
      chk(s_al, 32'h0);
      chk(s_stop, 32'h0);
      // error built up with servo off, then servo on
      wr(8'h00, 32'h1);
      rnd = lfsr(rnd);
      sv = (rnd & 32'h0000_003F) + 32'h0000_0040;
      cp = ((rnd >> 8) & 32'h0000_001F) + 32'h0000_0001;
      wr(8'h08, sv);
      wr(8'h0C, cp);
      push(1'b1, sv + 1);
      chk(s_al, 32'h0);
      wr(8'h00, 32'h3);
      snap();
      chk(s_al, 32'h2);
      chk(s_lim, 32'h1);
      chk(s_cc, cp);
      chk(s_cap, cp);
      push(1'b1, lv);
      chk(s_al, 32'h7);
      push(1'b0, sv + 1 + lv);
      chk(s_lim, 32'h0);
      chk(s_cc, 32'h0);
      wr(8'h18, 32'h1);
      snap();
      chk(s_al, 32'h0);
      stop_test();
   end
endmodule
